//--- hw/aop_pkg.sv
// shared constants and types for the converter output port and its host
package aop_pkg;
  // converter timing, in converter clock periods
  localparam int CONV_TOTAL = 8192;
  localparam int INT_LEN = 2048;
  localparam int DE_LEN = 4096;
  localparam int AZ_LEN = CONV_TOTAL - INT_LEN - DE_LEN;
  localparam int ZI_MAX = 1024;
  localparam int HOLD_BEFORE_INT = 7;
  localparam int XTAL_DIV = 58;
  localparam int CNT_W = 13;
  localparam int DIV_W = 6;
  // result word layout
  localparam int MAG_W = 12;
  localparam int BUS_W = 14;
  localparam int LOW_W = 8;
  localparam int HIGH_W = BUS_W - LOW_W;
  localparam int SIGN_BIT = 12;
  localparam int OVR_BIT = 13;
  localparam int SYNC_W = 10;
  // host register map, byte addresses
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CMD_OFS = 8'h04;
  localparam logic [7:0] RESULT_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0C;
  // control bit positions and reset value
  localparam int CTRL_MODE = 0;
  localparam int CTRL_RUN = 1;
  localparam int CTRL_TEST_N = 2;
  localparam int CTRL_OSC = 3;
  localparam int CTRL_SEND = 4;
  localparam logic [4:0] CTRL_RST = 5'h1E;
  localparam int CMD_READ = 0;
  localparam int STAT_FRESH = 0;
  localparam int STAT_BUSY = 1;
  localparam int STAT_CONV = 2;
  localparam int STAT_LOST = 3;
  localparam int HOST_RD_WAIT = 8;
  // converter phases, gray along az-int-de-zi
  typedef enum logic [1:0] {PH_AZ = 2'b00, PH_INT = 2'b01, PH_DE = 2'b11, PH_ZI = 2'b10}
    aop_phase_type;
  // handshake byte sequencer
  typedef enum logic [2:0] {HS_IDLE = 3'b000, HS_HI_FLAG = 3'b001, HS_HI_LOAD = 3'b011,
    HS_LO_FLAG = 3'b010, HS_LO_LOAD = 3'b110} aop_hs_type;
  // host direct-read sequencer
  typedef enum logic [1:0] {RD_IDLE = 2'b00, RD_HI = 2'b01, RD_LO = 2'b11} aop_rd_type;
endpackage

//--- hw/aop_if.sv
// pin-level link between converter output port and its host
`timescale 1ns/10ps
interface aop_if;
  import aop_pkg::*;
  logic mode;
  logic run_hold;
  logic test_n;
  logic oscillator_select;
  logic send;
  logic status;
  logic ce_load_dev_o, ce_load_dev_oe, ce_load_host_o, ce_load_host_oe, ce_load;
  logic high_byte_enable_dev_o, high_byte_enable_dev_oe;
  logic high_byte_enable_host_o, high_byte_enable_host_oe, high_byte_enable;
  logic low_byte_enable_dev_o, low_byte_enable_dev_oe;
  logic low_byte_enable_host_o, low_byte_enable_host_oe, low_byte_enable;
  logic [BUS_W-1:0] data_dev_o, data_dev_oe, data;
  // wire levels; undriven lines float to the pull-up level
  assign ce_load = ce_load_dev_oe ? ce_load_dev_o : (ce_load_host_oe ? ce_load_host_o : 1'b1);
  assign high_byte_enable = high_byte_enable_dev_oe ? high_byte_enable_dev_o :
    (high_byte_enable_host_oe ? high_byte_enable_host_o : 1'b1);
  assign low_byte_enable = low_byte_enable_dev_oe ? low_byte_enable_dev_o :
    (low_byte_enable_host_oe ? low_byte_enable_host_o : 1'b1);
  assign data = (data_dev_o & data_dev_oe) | ~data_dev_oe;
  modport device (input mode, run_hold, test_n, oscillator_select, send, ce_load,
    high_byte_enable, low_byte_enable, output status, ce_load_dev_o, ce_load_dev_oe,
    high_byte_enable_dev_o, high_byte_enable_dev_oe, low_byte_enable_dev_o,
    low_byte_enable_dev_oe, data_dev_o, data_dev_oe);
  modport host (output mode, run_hold, test_n, oscillator_select, send, ce_load_host_o,
    ce_load_host_oe, high_byte_enable_host_o, high_byte_enable_host_oe,
    low_byte_enable_host_o, low_byte_enable_host_oe, input status, ce_load,
    high_byte_enable, low_byte_enable, data);
endinterface

//--- hw/aop_device.sv
// converter digital section: conversion timing, result latch, output port
// Function
// - test low forces all bit outputs high
// - direct: chip and low enable drive low byte
// - direct: chip and high enable drive high byte
// - handshake: low enable pin flags low byte
// - handshake: high enable pin flags high byte
// - direct: chip enable high disables all bits
// - handshake: chip enable pin is load strobe
// - direct: three control pins are gating inputs
// - mode pulse starts handshake of latched result
// - mode held high: handshake after every conversion
// - rc select: converter clock equals oscillator
// - crystal select: converter clock divided by 58
// - run high: back-to-back 8192-period conversions
// - run low: finish, halt seven before integrate
// - receiver drives send when it accepts data
// - digital levels are positive true
// - status high integrate/de-integrate until latched
// - sign high positive; over-range high beyond scale
// - pulsed entry sends two bytes, returns direct
`timescale 1ns/10ps
module aop_device
  import aop_pkg::*;
#(
  parameter int DIV = XTAL_DIV
) (
  input wire logic core_clk, // oscillator clock
  input wire logic rst_n, // async reset, active low
  input wire logic clk_en, // freezes all state while low
  aop_if.device link, // pins toward the host
  input wire logic zero_cross, // comparator: integrator back at zero
  input wire logic int_polarity, // comparator: integrated signal positive
  output logic [1:0] phase_o // current converter phase
);
  // input synchronisers
  logic [SYNC_W-1:0] sync_a_reg, sync_b_reg, pins_in;
  logic mode_s, run_s, test_s, osc_s, send_s, ce_s, hbe_s, lbe_s, zc_s, pol_s;
  logic mode_d_reg;
  // clock scaling
  logic [DIV_W-1:0] div_reg, div_next;
  logic tick_reg, tick_next;
  // conversion sequencer
  aop_phase_type phase_reg, phase_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic done_reg, done_next, sign_reg, sign_next, status_next, latch;
  logic [BUS_W-1:0] res_reg, res_next;
  // handshake sequencer and pins
  aop_hs_type hs_reg, hs_next;
  logic hs_start, hs_mode, hi_on, lo_on;
  logic ctl_oe_reg, ctl_oe_next, ce_reg, ce_next, hbe_reg, hbe_next, lbe_reg, lbe_next;
  logic [BUS_W-1:0] dat_reg, dat_next, doe_reg, doe_next;
  logic status_reg;
  logic [1:0] phase_out_reg;

  // every level from the pins is sampled twice before use
  assign pins_in = {link.mode, link.run_hold, link.test_n, link.oscillator_select, link.send,
    link.ce_load, link.high_byte_enable, link.low_byte_enable, zero_cross, int_polarity};
  assign {mode_s, run_s, test_s, osc_s, send_s, ce_s, hbe_s, lbe_s, zc_s, pol_s} = sync_b_reg;

  // converter tick: every cycle for rc, one in DIV for crystal
  always_comb begin
    div_next = div_reg;
    tick_next = 1'b0;
    if (osc_s) begin
      div_next = '0;
      tick_next = 1'b1;
    end else if (div_reg == DIV_W'(DIV - 1)) begin
      div_next = '0;
      tick_next = 1'b1;
    end else begin
      div_next = div_reg + 1'b1;
    end
  end

  // phase sequencer; az length pads the cycle to a fixed total
  always_comb begin
    phase_next = phase_reg;
    cnt_next = cnt_reg;
    done_next = done_reg;
    sign_next = sign_reg;
    res_next = res_reg;
    latch = 1'b0;
    if (tick_reg) begin
      case (phase_reg)
        PH_AZ: begin
          if (cnt_reg == CNT_W'(AZ_LEN - 1)) begin
            phase_next = PH_INT;
            cnt_next = '0;
            done_next = 1'b0;
          end else if (cnt_reg == CNT_W'(AZ_LEN - HOLD_BEFORE_INT) && !run_s) begin
            cnt_next = cnt_reg;
          end else begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
        PH_INT: begin
          if (cnt_reg == CNT_W'(INT_LEN - 1)) begin
            phase_next = PH_DE;
            cnt_next = '0;
            sign_next = pol_s;
          end else begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
        PH_DE: begin
          cnt_next = cnt_reg + 1'b1;
          if (zc_s && !done_reg) begin
            latch = 1'b1;
            done_next = 1'b1;
            res_next = {1'b0, sign_reg, cnt_reg[MAG_W-1:0]};
          end else if (cnt_reg == CNT_W'(DE_LEN - 1) && !done_reg) begin
            latch = 1'b1;
            done_next = 1'b1;
            res_next = {1'b1, sign_reg, {MAG_W{1'b1}}};
          end
          // over-range goes through zero-integrate before auto-zero
          if (cnt_reg == CNT_W'(DE_LEN - 1) || (done_next && !run_s)) begin
            phase_next = res_next[OVR_BIT] ? PH_ZI : PH_AZ;
            cnt_next = '0;
          end
        end
        PH_ZI: begin
          cnt_next = cnt_reg + 1'b1;
          if (cnt_reg == CNT_W'(ZI_MAX - 1)) begin
            phase_next = PH_AZ;
          end
        end
        default: begin
          phase_next = PH_AZ;
          cnt_next = '0;
        end
      endcase
    end
    // status low from the latch on, and in az and zi
    status_next = (phase_next == PH_INT) || (phase_next == PH_DE && !done_next);
  end

  // handshake: high byte then low byte, each paced by send
  always_comb begin
    hs_next = hs_reg;
    hs_start = (latch && mode_s) || (mode_s && !mode_d_reg);
    case (hs_reg)
      HS_IDLE: if (hs_start) hs_next = HS_HI_FLAG;
      HS_HI_FLAG: if (tick_reg && send_s) hs_next = HS_HI_LOAD;
      HS_HI_LOAD: if (tick_reg) hs_next = HS_LO_FLAG;
      HS_LO_FLAG: if (tick_reg && send_s) hs_next = HS_LO_LOAD;
      HS_LO_LOAD: if (tick_reg) hs_next = HS_IDLE;
      default: hs_next = HS_IDLE;
    endcase
  end

  // pin drivers; flags and strobe are low-asserted like the enables they replace
  always_comb begin
    hs_mode = mode_s || (hs_reg != HS_IDLE);
    hi_on = (hs_reg == HS_HI_FLAG) || (hs_reg == HS_HI_LOAD);
    lo_on = (hs_reg == HS_LO_FLAG) || (hs_reg == HS_LO_LOAD);
    ctl_oe_next = hs_mode;
    hbe_next = !hi_on;
    lbe_next = !lo_on;
    ce_next = !((hs_reg == HS_HI_LOAD) || (hs_reg == HS_LO_LOAD));
    dat_next = res_reg;
    if (hs_mode) begin
      doe_next = {{HIGH_W{hi_on}}, {LOW_W{lo_on}}};
    end else begin
      // ce high masks both bytes whatever the byte enables say
      doe_next = {{HIGH_W{!ce_s && !hbe_s}}, {LOW_W{!ce_s && !lbe_s}}};
    end
    if (!test_s) begin
      dat_next = {BUS_W{1'b1}};
      doe_next = {BUS_W{1'b1}};
    end
  end

  // registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      // idle pin levels: mode low, the rest high, so no false mode edge after reset
      sync_a_reg <= {1'b0, {(SYNC_W-1){1'b1}}};
      sync_b_reg <= {1'b0, {(SYNC_W-1){1'b1}}};
      mode_d_reg <= 1'b0;
      div_reg <= '0;
      tick_reg <= 1'b0;
      phase_reg <= PH_AZ;
      cnt_reg <= '0;
      done_reg <= 1'b0;
      sign_reg <= 1'b0;
      res_reg <= '0;
      hs_reg <= HS_IDLE;
      ctl_oe_reg <= 1'b0;
      ce_reg <= 1'b1;
      hbe_reg <= 1'b1;
      lbe_reg <= 1'b1;
      dat_reg <= '0;
      doe_reg <= '0;
      status_reg <= 1'b0;
      phase_out_reg <= PH_AZ;
    end else if (clk_en) begin
      sync_a_reg <= pins_in;
      sync_b_reg <= sync_a_reg;
      mode_d_reg <= mode_s;
      div_reg <= div_next;
      tick_reg <= tick_next;
      phase_reg <= phase_next;
      cnt_reg <= cnt_next;
      done_reg <= done_next;
      sign_reg <= sign_next;
      res_reg <= res_next;
      hs_reg <= hs_next;
      ctl_oe_reg <= ctl_oe_next;
      ce_reg <= ce_next;
      hbe_reg <= hbe_next;
      lbe_reg <= lbe_next;
      dat_reg <= dat_next;
      doe_reg <= doe_next;
      status_reg <= status_next;
      phase_out_reg <= phase_next;
    end
  end

  assign link.status = status_reg;
  assign link.ce_load_dev_o = ce_reg;
  assign link.ce_load_dev_oe = ctl_oe_reg;
  assign link.high_byte_enable_dev_o = hbe_reg;
  assign link.high_byte_enable_dev_oe = ctl_oe_reg;
  assign link.low_byte_enable_dev_o = lbe_reg;
  assign link.low_byte_enable_dev_oe = ctl_oe_reg;
  assign link.data_dev_o = dat_reg;
  assign link.data_dev_oe = doe_reg;
  assign phase_o = phase_out_reg;
endmodule // aop_device

//--- hw/aop_host.sv
// host end: apb registers, direct bus reads and handshake byte capture
`timescale 1ns/10ps
module aop_host
  import aop_pkg::*;
#(
  parameter int RD_WAIT = HOST_RD_WAIT
) (
  input wire logic core_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic clk_en, // freezes all state while low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  aop_if.host link // pins toward the converter
);
  localparam int SW = BUS_W + 4;
  logic [SW-1:0] sa_reg, sb_reg;
  logic [BUS_W-1:0] d_s;
  logic ce_s, hbe_s, lbe_s, st_s, ce_d_reg;
  logic [4:0] ctrl_reg, ctrl_next;
  logic [BUS_W-1:0] res_reg, res_next;
  logic [3:0] stat_reg, stat_next;
  aop_rd_type rd_reg, rd_next;
  logic [3:0] wait_reg, wait_next;
  logic fresh_set, wr, rd_go;
  logic [31:0] prdata_next;
  logic pready_next, pslverr_next;

  function automatic logic hit(input logic [7:0] a);
    hit = (a == CTRL_OFS) || (a == CMD_OFS) || (a == RESULT_OFS) || (a == STAT_OFS);
  endfunction

  assign {d_s, ce_s, hbe_s, lbe_s, st_s} = sb_reg;
  assign wr = psel && penable && pready && pwrite;

  // direct read and handshake capture
  always_comb begin
    rd_next = rd_reg;
    wait_next = wait_reg;
    res_next = res_reg;
    fresh_set = 1'b0;
    rd_go = wr && (paddr == CMD_OFS) && pwdata[CMD_READ] && !ctrl_reg[CTRL_MODE];
    case (rd_reg)
      RD_IDLE: begin
        wait_next = '0;
        if (rd_go) rd_next = RD_HI;
      end
      RD_HI, RD_LO: begin
        wait_next = wait_reg + 1'b1;
        if (wait_reg == 4'(RD_WAIT - 1)) begin
          wait_next = '0;
          if (rd_reg == RD_HI) begin
            res_next[BUS_W-1:LOW_W] = d_s[BUS_W-1:LOW_W];
            rd_next = RD_LO;
          end else begin
            res_next[LOW_W-1:0] = d_s[LOW_W-1:0];
            fresh_set = 1'b1;
            rd_next = RD_IDLE;
          end
        end
      end
      default: rd_next = RD_IDLE;
    endcase
    // device strobe fall while no direct read runs; after a mode pulse
    // the control bit is already low when the bytes arrive
    if (rd_reg == RD_IDLE && ce_d_reg && !ce_s) begin
      if (!hbe_s) res_next[BUS_W-1:LOW_W] = d_s[BUS_W-1:LOW_W];
      if (!lbe_s) begin
        res_next[LOW_W-1:0] = d_s[LOW_W-1:0];
        fresh_set = 1'b1;
      end
    end
  end

  // apb slave, no wait states; a fresh result beats a same-cycle clear
  always_comb begin
    ctrl_next = ctrl_reg;
    stat_next = stat_reg;
    if (wr && paddr == CTRL_OFS) ctrl_next = pwdata[4:0];
    if (wr && paddr == STAT_OFS) begin
      stat_next[STAT_FRESH] = stat_reg[STAT_FRESH] & ~pwdata[STAT_FRESH];
      stat_next[STAT_LOST] = stat_reg[STAT_LOST] & ~pwdata[STAT_LOST];
    end
    if (fresh_set) begin
      stat_next[STAT_LOST] = stat_next[STAT_LOST] | stat_reg[STAT_FRESH];
      stat_next[STAT_FRESH] = 1'b1;
    end
    stat_next[STAT_BUSY] = rd_next != RD_IDLE;
    stat_next[STAT_CONV] = st_s;
    pready_next = psel && !penable && !pready;
    pslverr_next = pready_next && !hit(paddr);
    prdata_next = '0;
    if (pready_next && !pwrite) begin
      case (paddr)
        CTRL_OFS: prdata_next = {27'h0000000, ctrl_reg};
        RESULT_OFS: prdata_next = {18'h00000, res_reg};
        STAT_OFS: prdata_next = {28'h0000000, stat_reg};
        default: prdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sa_reg <= '1;
      sb_reg <= '1;
      ce_d_reg <= 1'b1;
      ctrl_reg <= CTRL_RST;
      res_reg <= '0;
      stat_reg <= '0;
      rd_reg <= RD_IDLE;
      wait_reg <= '0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      sa_reg <= {link.data, link.ce_load, link.high_byte_enable, link.low_byte_enable,
        link.status};
      sb_reg <= sa_reg;
      ce_d_reg <= ce_s;
      ctrl_reg <= ctrl_next;
      res_reg <= res_next;
      stat_reg <= stat_next;
      rd_reg <= rd_next;
      wait_reg <= wait_next;
      prdata <= prdata_next;
      pready <= pready_next;
      pslverr <= pslverr_next;
    end
  end

  // pins: byte enables driven only in direct mode; send paces the device
  assign link.mode = ctrl_reg[CTRL_MODE];
  assign link.run_hold = ctrl_reg[CTRL_RUN];
  assign link.test_n = ctrl_reg[CTRL_TEST_N];
  assign link.oscillator_select = ctrl_reg[CTRL_OSC];
  assign link.send = ctrl_reg[CTRL_SEND];
  assign link.ce_load_host_o = rd_reg == RD_IDLE;
  assign link.high_byte_enable_host_o = rd_reg != RD_HI;
  assign link.low_byte_enable_host_o = rd_reg != RD_LO;
  assign link.ce_load_host_oe = !ctrl_reg[CTRL_MODE];
  assign link.high_byte_enable_host_oe = !ctrl_reg[CTRL_MODE];
  assign link.low_byte_enable_host_oe = !ctrl_reg[CTRL_MODE];
endmodule // aop_host

//--- verification/aop_monitor.sv
// concurrent checks on the pins between converter output port and host
`timescale 1ns/10ps
module aop_monitor
  import aop_pkg::*;
(
  input wire logic core_clk, // clock
  input wire logic rst_n, // async reset, active low
  input wire logic mode, // handshake select
  input wire logic run_hold, // run request
  input wire logic test_n, // force outputs high when low
  input wire logic oscillator_select, // rc when high
  input wire logic send, // receiver ready
  input wire logic status, // conversion busy
  input wire logic ce_load, // resolved chip enable / load
  input wire logic ce_load_dev_o, // device strobe value
  input wire logic ce_load_dev_oe, // device strobe enable
  input wire logic high_byte_enable, // resolved high enable
  input wire logic high_byte_enable_dev_o, // device high flag
  input wire logic high_byte_enable_dev_oe, // device high flag enable
  input wire logic low_byte_enable, // resolved low enable
  input wire logic low_byte_enable_dev_o, // device low flag
  input wire logic low_byte_enable_dev_oe, // device low flag enable
  input wire logic [BUS_W-1:0] data_dev_o, // device data
  input wire logic [BUS_W-1:0] data_dev_oe // device data enables
);
  default clocking mon_cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // status high time in rc cycles only: crystal cycles do not tick every clock,
  // so counting them would make the bound depend on the divide
  int unsigned st_cnt;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) st_cnt <= 0;
    else st_cnt <= status ? (oscillator_select ? st_cnt + 1 : st_cnt) : 0;
  end
  // inputs pass a two-stage sync and an output register, hence four cycles
  test_force_a: assert property ((!test_n) [*4] |-> (&data_dev_oe) && (&data_dev_o))
    else $error("test input did not force outputs high");
  ce_disable_a: assert property ((!mode && !ce_load_dev_oe && ce_load && test_n)
    [*4] |-> data_dev_oe == 14'h0000) else $error("bits driven with chip enable high");
  low_gate_a: assert property ((!mode && !ce_load_dev_oe && !ce_load
    && high_byte_enable && !low_byte_enable && test_n) [*4] |-> data_dev_oe == 14'h00FF)
    else $error("low byte gating wrong");
  high_gate_a: assert property ((!mode && !ce_load_dev_oe && !ce_load
    && !high_byte_enable && low_byte_enable && test_n) [*4] |-> data_dev_oe == 14'h3F00)
    else $error("high byte gating wrong");
  strobe_flag_a: assert property (ce_load_dev_oe && !ce_load_dev_o
    |-> high_byte_enable ^ low_byte_enable) else $error("strobe without single byte flag");
  flag_data_a: assert property (high_byte_enable_dev_oe && !high_byte_enable_dev_o
    |-> &data_dev_oe[13:8]) else $error("high flag without high bits");
  low_flag_a: assert property (low_byte_enable_dev_oe && !low_byte_enable_dev_o
    |-> &data_dev_oe[7:0]) else $error("low flag without low bits");
  send_pace_a: assert property ($fell(ce_load) && ce_load_dev_oe
    |-> $past(send, 2)) else $error("strobe while receiver not ready");
  strobe_len_a: assert property ($fell(ce_load) && ce_load_dev_oe
    && oscillator_select |=> ce_load) else $error("rc strobe longer than one cycle");
  run_start_a: assert property ($rose(status) && oscillator_select
    |-> $past(run_hold, 7)) else $error("integrate began too soon after run");
  status_len_a: assert property (st_cnt <= 6160)
    else $error("status high too long");
endmodule // aop_monitor

//--- verification/adc_output_port_and_conversion_control_bench.sv
// self-checking bench: host and converter port joined through the pin interface
`timescale 1ns/10ps
module adc_output_port_and_conversion_control_bench;
  import aop_pkg::*;
  localparam int DIVS = 4; // short crystal divide keeps the run brief
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] phase; // converter phase seen from the device
  logic zero_cross = 1'b0; // never crosses: every result is over-range
  logic int_polarity = 1'b0; // negative input
  int errors = 0;
  int n_compared = 0;
  aop_if link_if();
  aop_device #(.DIV(DIVS)) aop_device_i(.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1),
    .link(link_if.device), .zero_cross(zero_cross), .int_polarity(int_polarity), .phase_o(phase));
  aop_host aop_host_i(.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link_if.host));
  aop_monitor aop_monitor_i(.core_clk(core_clk), .rst_n(rst_n), .mode(link_if.mode),
    .run_hold(link_if.run_hold), .test_n(link_if.test_n), .status(link_if.status),
    .oscillator_select(link_if.oscillator_select), .send(link_if.send),
    .ce_load(link_if.ce_load), .ce_load_dev_o(link_if.ce_load_dev_o),
    .ce_load_dev_oe(link_if.ce_load_dev_oe), .high_byte_enable(link_if.high_byte_enable),
    .high_byte_enable_dev_o(link_if.high_byte_enable_dev_o),
    .high_byte_enable_dev_oe(link_if.high_byte_enable_dev_oe),
    .low_byte_enable(link_if.low_byte_enable),
    .low_byte_enable_dev_o(link_if.low_byte_enable_dev_o),
    .low_byte_enable_dev_oe(link_if.low_byte_enable_dev_oe),
    .data_dev_o(link_if.data_dev_o), .data_dev_oe(link_if.data_dev_oe));
  // 40 MHz clock
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  task end_of_test;
    if (errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer, entered just after a rising edge; holds until pready is sampled
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
      output logic err);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      errors++;
      end_of_test;
    end
    @(posedge core_clk);
  endtask
  task wr_ctrl(input logic [31:0] v);
    logic [31:0] r;
    logic e;
    apb(1'b1, CTRL_OFS, v, r, e);
  endtask
  task wait_st(input logic v, input int lim);
    int i;
    i = 0;
    while (link_if.status !== v && i < lim) begin
      @(posedge core_clk);
      i++;
    end
    if (i >= lim) begin
      errors++;
      end_of_test;
    end
  endtask
  // count falling edges of the load strobe over a fixed window
  task strobes(input int cyc, output int n);
    logic p;
    p = 1'b1;
    n = 0;
    repeat (cyc) begin
      @(posedge core_clk);
      if (p === 1'b1 && link_if.ce_load === 1'b0) n++;
      p = link_if.ce_load;
    end
  endtask
  // host direct read through chip and byte enables, then fetch the captured word
  task rd_direct(output logic [31:0] v);
    logic [31:0] r;
    logic e;
    int i;
    apb(1'b1, CMD_OFS, 32'h00000001, r, e);
    for (i = 0; i < 20; i++) begin
      apb(1'b0, STAT_OFS, 32'h00000000, r, e);
      if (r[STAT_BUSY] === 1'b0) break;
    end
    chk("busy", 32'h00000000, {31'h0, r[STAT_BUSY]});
    chk("fresh", 32'h00000001, {31'h0, r[STAT_FRESH]});
    apb(1'b0, RESULT_OFS, 32'h00000000, v, e);
  endtask
  task pulse_mode(input logic [31:0] base);
    wr_ctrl(base | 32'h00000001);
    repeat (4) @(posedge core_clk);
    wr_ctrl(base);
  endtask
  task s_reset;
    logic [31:0] r;
    logic e;
    apb(1'b0, CTRL_OFS, 32'h00000000, r, e);
    chk("ctrl reset", 32'h0000001E, r);
    apb(1'b0, 8'h10, 32'h00000000, r, e);
    chk("unmapped err", 32'h00000001, {31'h0, e});
    chk("unmapped data", 32'h00000000, r);
  endtask
  // over-range conversion of a negative input, read over the direct bus
  task s_conv;
    logic [31:0] r;
    wait_st(1'b1, 3000);
    wait_st(1'b0, 9000);
    chk("zero integrate", {30'h0, PH_ZI}, {30'h0, phase});
    rd_direct(r);
    chk("result", 32'h00002FFF, r);
    wr_ctrl(32'h0000001A);
    rd_direct(r);
    chk("forced result", 32'h00003FFF, r);
    wr_ctrl(32'h0000001E);
  endtask
  // pulsed entry: two bytes, high first, then back to direct
  task s_pulse;
    logic [31:0] r;
    logic e;
    int n;
    // count from before the pulse: both bytes go out before the second write returns
    fork
      pulse_mode(32'h0000001E);
      strobes(100, n);
    join
    chk("pulse strobes", 32'h00000002, n);
    chk("port released", 32'h00000000, {31'h0, link_if.ce_load_dev_oe});
    apb(1'b0, RESULT_OFS, 32'h00000000, r, e);
    chk("handshake bytes", 32'h00002FFF, r);
  endtask
  // receiver not ready: high flag held, no load strobe until send returns
  task s_stall;
    int n;
    pulse_mode(32'h0000000E);
    repeat (40) @(posedge core_clk);
    chk("no strobe", 32'h00000001, {31'h0, link_if.ce_load});
    chk("high flag", 32'h00000000, {31'h0, link_if.high_byte_enable});
    wr_ctrl(32'h0000001E);
    strobes(100, n);
    chk("stall strobes", 32'h00000002, n);
  endtask
  // crystal select: each converter tick spans the divide count
  task s_xtal;
    int i;
    int n;
    pulse_mode(32'h00000016);
    i = 0;
    while (link_if.ce_load !== 1'b0 && i < 300) begin
      @(posedge core_clk);
      i++;
    end
    n = 0;
    while (link_if.ce_load === 1'b0 && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    chk("strobe width", DIVS, n);
    strobes(300, n);
    chk("xtal second strobe", 32'h00000001, n);
    wr_ctrl(32'h0000001E);
  endtask
  // hold: no new integrate while run is low; mode held high sends after each conversion
  task s_hold;
    int n;
    wr_ctrl(32'h0000001C);
    wait_st(1'b0, 9000);
    repeat (3000) @(posedge core_clk);
    chk("held status", 32'h00000000, {31'h0, link_if.status});
    chk("held phase", {30'h0, PH_AZ}, {30'h0, phase});
    wr_ctrl(32'h0000001F);
    wait_st(1'b1, 30);
    wait_st(1'b0, 9000);
    strobes(100, n);
    chk("held mode strobes", 32'h00000002, n);
    wr_ctrl(32'h0000001E);
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    s_reset;
    s_conv;
    s_pulse;
    s_stall;
    s_xtal;
    s_hold;
    end_of_test;
  end
endmodule // adc_output_port_and_conversion_control_bench
